// ### core/sppf_core.sv
// serial peripheral port: master/slave shifter with transmit and receive fifos
`timescale 1ns/1ps
// Functional notes
// R1: words of 1 to 16 bits, full duplex
// R2: only the master makes the serial clock
// R3: shift out one edge, capture the other
// R4: phase bit moves data half cycle earlier
// R5: idle high, no delay: drive fall, sample rise
// R6: idle high, delay: drive early, sample fall
// R7: idle low, no delay: drive rise, sample fall
// R8: idle low, delay: drive early, sample rise
// R9: transmit can be disabled, reception continues
// R10: sixteen-word fifos, bypassable by enable bit
// R11: period is divide by 4 or baud+1
// R12: period 4..128 even, 5..127 odd cycles
// R13: odd divisor: first pulse half cycle longer
// R14: select leads first edge 1.5 periods minus 3
// R15: select released half period after last edge
// R16: role bit and clock polarity bit
// R17: eight-bit payload, upper byte zero
// R18: twelve registers framed at fixed base
// R19: events serviceable by polling status flags
// R20: software keeps serial clock under limits
// R21: deselected slave ignores clock, floats output
// R22: finished word stored and flagged
module sppf_core (
  input  wire logic        mclk_i,        // 25 MHz clock
  input  wire logic        rst_i,         // async reset, high
  input  wire logic        cfg_master_i,  // 1 master, 0 slave
  input  wire logic        cfg_pol_i,     // 1 clock idles high
  input  wire logic        cfg_pha_i,     // 1 half-cycle early data
  input  wire logic        cfg_talk_i,    // 1 transmit enabled
  input  wire logic        cfg_fifo_en_i, // 1 fifos in use
  input  wire logic [3:0]  cfg_len_i,     // word length minus one
  input  wire logic [6:0]  cfg_baud_i,    // baud divisor
  input  wire logic [15:0] tx_data_i,     // word to send
  input  wire logic        tx_valid_i,    // word offered
  output logic             tx_ready_o,    // room for a word
  output logic      [15:0] rx_data_o,     // received word
  output logic             rx_valid_o,    // received word waiting
  input  wire logic        rx_ready_i,    // received word taken
  output logic             rx_word_o,     // pulse: word finished
  output logic             ovr_o,         // sticky receive overrun
  input  wire logic        ovr_clr_i,     // clears overrun
  input  wire logic        sclk_i,        // serial clock in
  output logic             sclk_o,        // serial clock out
  output logic             sclk_oe_o,     // serial clock driven
  input  wire logic        ste_n_i,       // slave select in
  output logic             ste_n_o,       // slave select out
  output logic             ste_n_oe_o,    // slave select driven
  input  wire logic        simo_i,        // slave_in_master_out in
  output logic             simo_o,        // slave_in_master_out out
  output logic             simo_oe_o,     // slave_in_master_out driven
  input  wire logic        somi_i,        // slave_out_master_in in
  output logic             somi_o,        // slave_out_master_in out
  output logic             somi_oe_o      // slave_out_master_in driven
);
  sppf_strm_if #(.W(sppf_pkg::DW)) txw ();
  sppf_strm_if #(.W(sppf_pkg::DW)) txr ();
  sppf_strm_if #(.W(sppf_pkg::DW)) rxw ();
  sppf_strm_if #(.W(sppf_pkg::DW)) rxr ();

  sppf_pkg::sppf_state_t st_r;
  logic [7:0]  cnt_r, per_c, h0_c, h1_c, lead_c;
  logic [3:0]  bit_r;
  logic [15:0] sh_r, ld_word, rx_word;
  logic [15:0] rxd_r;
  logic [4:0]  lim, tx_lvl;
  logic        half_r, wd_r, out_r, sclk_r, sclk_d_r, ste_r, rxv_r, ovr_r;
  logic        sclk_oe_r, ste_oe_r, simo_oe_r, somi_oe_r;
  logic        m_lead, m_trail, s_act, s_lead, s_trail, lead, trail;
  logic        samp, drv, last, done, load, sin;

  // bit of a word that goes out next
  function automatic logic pick(input logic [15:0] v, input logic [3:0] n);
    return v[n];
  endfunction : pick

  // mask keeping the low n+1 bits of a received word
  function automatic logic [15:0] lmask(input logic [3:0] n);
    return 16'hFFFF >> (4'hF - n);
  endfunction : lmask

  // fifos: limit of one word is the bypass, a single holding stage
  assign lim = cfg_fifo_en_i ? sppf_pkg::LIM_FULL : sppf_pkg::LIM_BYP; // R10
  sppf_fifo #(.W(sppf_pkg::DW), .D(sppf_pkg::FD)) u_txf (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .lim_i   (lim),
    .wr      (txw),
    .rd      (txr),
    .level_o (tx_lvl)
  );
  sppf_fifo #(.W(sppf_pkg::DW), .D(sppf_pkg::FD)) u_rxf (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .lim_i   (lim),
    .wr      (rxw),
    .rd      (rxr),
    .level_o ()
  );

  // user side of both fifos; ready and valid double as polled status
  assign txw.data   = tx_data_i;
  assign txw.valid  = tx_valid_i;
  assign tx_ready_o = txw.ready; // R19
  assign txr.ready  = load;
  assign rxw.data   = rxd_r;
  assign rxw.valid  = rxv_r;
  assign rx_data_o  = rxr.data;
  assign rx_valid_o = rxr.valid; // R19
  assign rxr.ready  = rx_ready_i;

  // period and half-pulse lengths; odd periods make the first half longer
  assign per_c  = sppf_pkg::sppf_period(cfg_baud_i); // R11 R12
  assign h0_c   = (per_c + 8'h01) >> 1; // R13
  assign h1_c   = per_c >> 1;
  assign lead_c = per_c + h1_c - sppf_pkg::LEAD_SYS; // R14

  // edge events: master from its own half counter, slave from the pin
  assign m_lead  = cfg_master_i && cnt_r == 8'h00 &&
                   (st_r == sppf_pkg::ST_LEAD || (st_r == sppf_pkg::ST_SHIFT && half_r));
  assign m_trail = cfg_master_i && cnt_r == 8'h00 && st_r == sppf_pkg::ST_SHIFT && !half_r;
  assign s_act   = !cfg_master_i && !ste_n_i && st_r == sppf_pkg::ST_SHIFT; // R2 R21
  assign s_lead  = s_act && sclk_d_r == cfg_pol_i && sclk_i != cfg_pol_i;
  assign s_trail = s_act && sclk_d_r != cfg_pol_i && sclk_i == cfg_pol_i;
  assign lead    = m_lead || s_lead;
  assign trail   = m_trail || s_trail;

  // phase picks which edge samples and which drives
  assign samp = cfg_pha_i ? lead : trail; // R3 R4 R5 R6 R7 R8
  assign drv  = cfg_pha_i ? trail : lead; // R3 R4 R5 R6 R7 R8
  assign last = bit_r == cfg_len_i; // R1
  assign done = samp && last;
  assign sin  = cfg_master_i ? somi_i : simo_i; // R16

  // a master starts on queued data; a slave loads when selected
  assign load    = st_r == sppf_pkg::ST_IDLE && (cfg_master_i ? txr.valid : !ste_n_i); // R2
  assign ld_word = txr.valid ? txr.data : '0;
  assign rx_word = {sh_r[14:0], sin} & lmask(cfg_len_i);

  // sequencer: select lead, shifting halves, select tail
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r   <= sppf_pkg::ST_IDLE;
      cnt_r  <= 8'h00;
      half_r <= 1'b0;
    end else begin
      case (st_r)
        sppf_pkg::ST_IDLE: begin
          half_r <= 1'b0;
          if (load) begin
            st_r  <= cfg_master_i ? sppf_pkg::ST_LEAD : sppf_pkg::ST_SHIFT; // R16
            cnt_r <= lead_c - 8'h01; // R14
          end
        end
        sppf_pkg::ST_LEAD: begin
          if (cnt_r == 8'h00) begin
            st_r  <= sppf_pkg::ST_SHIFT;
            cnt_r <= h0_c - 8'h01; // R13
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        sppf_pkg::ST_SHIFT: begin
          if (!cfg_master_i) begin
            if (ste_n_i || done) st_r <= sppf_pkg::ST_IDLE; // R21
          end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (half_r) begin
            half_r <= 1'b0;
            cnt_r  <= h0_c - 8'h01; // R13
          end else if (wd_r || done) begin
            st_r  <= sppf_pkg::ST_TAIL;
            cnt_r <= h1_c - 8'h01; // R15
          end else begin
            half_r <= 1'b1;
            cnt_r  <= h1_c - 8'h01; // R12
          end
        end
        sppf_pkg::ST_TAIL: begin
          if (cnt_r == 8'h00) st_r <= sppf_pkg::ST_IDLE; // R15
          else cnt_r <= cnt_r - 8'h01;
        end
        default: st_r <= sppf_pkg::ST_IDLE;
      endcase
    end
  end

  // shift register, bit count and word-finished marker
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_r  <= '0;
      bit_r <= 4'h0;
      wd_r  <= 1'b0;
    end else if (load) begin
      sh_r  <= ld_word;
      bit_r <= 4'h0;
      wd_r  <= 1'b0;
    end else if (samp) begin
      sh_r  <= {sh_r[14:0], sin}; // R3
      bit_r <= last ? 4'h0 : bit_r + 4'h1; // R1
      if (last) wd_r <= 1'b1;
    end
  end

  // serial data out: first bit at load, then on each drive edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)     out_r <= 1'b0;
    else if (load) out_r <= pick(ld_word, cfg_len_i); // R4
    else if (drv)  out_r <= pick(sh_r, cfg_len_i); // R3
  end

  // serial clock: toggles on master edges, rests at idle level
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)                          sclk_r <= 1'b0;
    else if (m_lead || m_trail)         sclk_r <= ~sclk_r; // R2
    else if (st_r == sppf_pkg::ST_IDLE) sclk_r <= cfg_pol_i; // R16
  end

  // select: low from load through the tail in master mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)              ste_r <= 1'b1;
    else if (!cfg_master_i) ste_r <= 1'b1;
    else if (load)          ste_r <= 1'b0; // R14
    else if (st_r == sppf_pkg::ST_TAIL && cnt_r == 8'h00) ste_r <= 1'b1; // R15
  end

  // pin drivers; a deselected slave floats its data out
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_oe_r <= 1'b0;
      ste_oe_r  <= 1'b0;
      simo_oe_r <= 1'b0;
      somi_oe_r <= 1'b0;
      sclk_d_r  <= 1'b0;
    end else begin
      sclk_oe_r <= cfg_master_i; // R2
      ste_oe_r  <= cfg_master_i;
      simo_oe_r <= cfg_master_i && cfg_talk_i; // R9
      somi_oe_r <= !cfg_master_i && cfg_talk_i && !ste_n_i; // R9 R21
      sclk_d_r  <= sclk_i;
    end
  end

  // finished word goes to the receive fifo; a refused word is overrun
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rxv_r <= 1'b0;
      rxd_r <= '0;
      ovr_r <= 1'b0;
    end else begin
      rxv_r <= done; // R22
      if (done) rxd_r <= rx_word; // R22
      if (rxv_r && !rxw.ready) ovr_r <= 1'b1; // set wins over clear
      else if (ovr_clr_i)      ovr_r <= 1'b0;
    end
  end

  assign sclk_o     = sclk_r;
  assign sclk_oe_o  = sclk_oe_r;
  assign ste_n_o    = ste_r;
  assign ste_n_oe_o = ste_oe_r;
  assign simo_o     = out_r;
  assign simo_oe_o  = simo_oe_r;
  assign somi_o     = out_r;
  assign somi_oe_o  = somi_oe_r;
  assign rx_word_o  = rxv_r;
  assign ovr_o      = ovr_r;

  // helper: cycles since the serial clock last changed
  logic [7:0] gap_r;
  logic       sclk_q_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r    <= 8'h00;
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= sclk_r;
      if (sclk_r != sclk_q_r)  gap_r <= 8'h01;
      else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_slv_noclk;
    !$past(cfg_master_i) |-> !sclk_oe_o && !ste_n_oe_o;
  endproperty
  a_slv_noclk: assert property (p_slv_noclk) else $error("slave drives clock"); // R2

  property p_desel_float;
    !$past(cfg_master_i) && $past(ste_n_i) |-> !somi_oe_o;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("deselected slave drives"); // R21

  property p_talk_off;
    !$past(cfg_talk_i) |-> !simo_oe_o && !somi_oe_o;
  endproperty
  a_talk_off: assert property (p_talk_off) else $error("transmit not disabled"); // R9

  property p_lead;
    $fell(ste_n_o) |-> $stable(sclk_o)[*3];
  endproperty
  a_lead: assert property (p_lead) else $error("select lead too short"); // R14

  property p_tail;
    $rose(ste_n_o) && $past(cfg_master_i) |-> gap_r == h1_c;
  endproperty
  a_tail: assert property (p_tail) else $error("select tail wrong"); // R15

  property p_half;
    $changed(sclk_o) && $past(st_r == sppf_pkg::ST_SHIFT) |->
      gap_r == ($past(half_r) ? h1_c : h0_c);
  endproperty
  a_half: assert property (p_half) else $error("serial clock half wrong"); // R13

  property p_range;
    $changed(sclk_o) && $past(st_r == sppf_pkg::ST_SHIFT) |-> gap_r >= 8'h02 && gap_r <= 8'h40;
  endproperty
  a_range: assert property (p_range) else $error("serial clock out of range"); // R12

  property p_len;
    st_r == sppf_pkg::ST_SHIFT |-> bit_r <= cfg_len_i;
  endproperty
  a_len: assert property (p_len) else $error("bit count past length"); // R1

  property p_word;
    done |=> rx_word_o ##1 !rx_word_o || $past(done);
  endproperty
  a_word: assert property (p_word) else $error("finished word not flagged"); // R22

  property p_byp;
    !cfg_fifo_en_i && $past(!cfg_fifo_en_i) && $past(tx_lvl) <= 5'h01 |-> tx_lvl <= 5'h01;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass holds over one word"); // R10

  c_mword: cover property (cfg_master_i && done);
  c_sword: cover property (!cfg_master_i && done);
  c_odd:   cover property (cfg_baud_i[0] && cfg_baud_i > 7'h03 && m_trail);
  c_ovr:   cover property ($rose(ovr_o));
endmodule : sppf_core

// ### inc/sppf_pkg.sv
// constants, state type and period function for the serial peripheral port
package sppf_pkg;
  localparam int          DW        = 16;        // shift word width
  localparam int          FD        = 16;        // fifo depth
  localparam int          CW        = 5;         // fifo level width
  localparam logic [4:0]  LIM_FULL  = 5'h10;     // fifo in use
  localparam logic [4:0]  LIM_BYP   = 5'h01;     // fifo bypassed
  localparam logic [6:0]  BAUD_MIN  = 7'h03;     // below this the divider is fixed
  localparam logic [7:0]  DIV_FIX   = 8'h04;     // fixed clock divide
  localparam logic [7:0]  LEAD_SYS  = 8'h03;     // select lead shortened by this
  localparam logic [15:0] REG_BASE  = 16'h7040;  // R18
  localparam logic [15:0] DATA_MASK = 16'h00FF;  // R17

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL} sppf_state_t;

  // serial clock period in clock cycles from the baud setting
  function automatic logic [7:0] sppf_period(input logic [6:0] b);
    return (b < BAUD_MIN) ? DIV_FIX : {1'b0, b} + 8'h01; // R11
  endfunction : sppf_period
endpackage : sppf_pkg

// ### inc/sppf_strm_if.sv
// valid/ready word stream between the port core and its fifos
`timescale 1ns/1ps
interface sppf_strm_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sppf_strm_if

// ### core/sppf_fifo.sv
// word fifo with registered read data and a programmable fill limit
`timescale 1ns/1ps
module sppf_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                   mclk_i,  // clock
  input  wire logic                   rst_i,   // async reset
  input  wire logic [$clog2(D+1)-1:0] lim_i,   // usable depth
  sppf_strm_if.snk                    wr,      // fill side
  sppf_strm_if.src                    rd,      // drain side
  output logic      [$clog2(D+1)-1:0] level_o  // words held
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [W-1:0]  rd_r;
  logic          rdy_r, vld_r, push, pop;

  assign push    = wr.valid && rdy_r;
  assign pop     = vld_r && rd.ready;
  assign rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  // storage has no reset; only pointers define what is valid
  always_ff @(posedge mclk_i) begin
    if (push) mem[wp_r] <= wr.data;
  end

  // pointers, level and flags; ready compares against the limit
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
      vld_r <= 1'b0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= cnt_nxt < lim_i;
      vld_r <= cnt_nxt != '0;
    end
  end

  // head word is forwarded when written into the slot being read next
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rd_r <= '0;
    else       rd_r <= (push && wp_r == rp_nxt) ? wr.data : mem[rp_nxt];
  end

  assign wr.ready = rdy_r;
  assign rd.valid = vld_r;
  assign rd.data  = rd_r;
  assign level_o  = cnt_r;
endmodule : sppf_fifo

// ### test/sppf_peer.sv
// behavioural far-side device: slave while the port is master, master otherwise
`timescale 1ns/1ps
module sppf_peer (
  input  wire logic       mclk_i,          // clock
  input  wire logic       role_i,          // 1 port is master
  input  wire logic       pol_i,           // clock idles high
  input  wire logic       pha_i,           // half-cycle early data
  input  wire logic [3:0] len_i,           // word length minus one
  input  wire logic       sclk_i,          // serial clock wire
  input  wire logic       ste_n_i,         // select wire
  input  wire logic       simo_i,          // master data wire
  input  wire logic       somi_i,          // slave data wire
  output logic            somi_o = 1'b0,   // slave data drive
  output logic            sclk_o = 1'b0,   // clock drive
  output logic            ste_n_o = 1'b1,  // select drive
  output logic            simo_o = 1'b0    // master data drive
);
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  logic        sclk_q  = 1'b0;
  int          e       = 0;
  int          idx     = 0;

  // slave side: edges seen one clock late, which the half periods of 2+ cycles allow
  always @(posedge mclk_i) begin
    sclk_q <= sclk_i;
    if (!role_i || ste_n_i) begin
      e <= 0;
      idx <= 0;
      somi_o <= tx_word[len_i];
    end else if (sclk_i != sclk_q) begin
      e <= e + 1;
      if (e[0] != pha_i) begin
        rx_word <= {rx_word[14:0], simo_i};
      end else if (pha_i || e != 0) begin
        idx <= idx + 1;
        if (idx < len_i) somi_o <= tx_word[len_i - idx - 1];
      end
    end
  end

  // master side: this end alone makes the clock, h cycles each half
  task automatic xfer(input int h);
    sclk_o = pol_i;
    repeat (h) @(negedge mclk_i);
    ste_n_o = 1'b0;
    simo_o = tx_word[len_i];
    for (int k = 0; k <= len_i; k++) begin
      repeat (h) @(negedge mclk_i);
      sclk_o = !pol_i;
      if (pha_i) rx_word = {rx_word[14:0], somi_i};
      else if (k > 0) simo_o = tx_word[len_i - k];
      repeat (h) @(negedge mclk_i);
      sclk_o = pol_i;
      if (!pha_i) rx_word = {rx_word[14:0], somi_i};
      else if (k < len_i) simo_o = tx_word[len_i - k - 1];
    end
    repeat (h) @(negedge mclk_i);
    ste_n_o = 1'b1;
  endtask : xfer

  // clock edges while the select stays high
  task automatic wiggle(input int n);
    repeat (n) begin
      repeat (4) @(negedge mclk_i);
      sclk_o = !sclk_o;
    end
  endtask : wiggle
endmodule : sppf_peer

// ### test/sppf_core_tb_top.sv
// self-checking bench for the serial peripheral port core
`timescale 1ns/1ps
module sppf_core_tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        master, pol, pha, talk, fen, tx_valid, rx_ready, ovr_clr, flip;
  logic [3:0]  len;
  logic [6:0]  baud;
  logic [15:0] tx_data, rx_data_o;
  logic        tx_ready_o, rx_valid_o, rx_word_o, ovr_o, sclk_o, sclk_oe_o, ste_n_o;
  logic        ste_n_oe_o, simo_o, simo_oe_o, somi_o, somi_oe_o;
  logic        p_somi, p_sclk, p_ste_n, p_simo;
  wire         sclk_w, ste_w, simo_w, somi_w;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_words    = 0;
  int          seq        = 1;
  logic [6:0]  seq_b [4]  = '{7'h00, 7'h04, 7'h7E, 7'h7F};

  // pin wires: a data line driven by neither end shows a changing pattern, never a held value
  assign sclk_w = sclk_oe_o ? sclk_o : p_sclk;
  assign ste_w  = ste_n_oe_o ? ste_n_o : p_ste_n;
  assign simo_w = simo_oe_o ? simo_o : (!master && !p_ste_n) ? p_simo : flip;
  assign somi_w = somi_oe_o ? somi_o : (master && !ste_w) ? p_somi : flip;

  sppf_core DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .cfg_master_i(master), .cfg_pol_i(pol),
    .cfg_pha_i(pha), .cfg_talk_i(talk), .cfg_fifo_en_i(fen), .cfg_len_i(len),
    .cfg_baud_i(baud), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready), .rx_word_o(rx_word_o), .ovr_o(ovr_o), .ovr_clr_i(ovr_clr),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .ste_n_i(ste_w),
    .ste_n_o(ste_n_o), .ste_n_oe_o(ste_n_oe_o), .simo_i(simo_w), .simo_o(simo_o),
    .simo_oe_o(simo_oe_o), .somi_i(somi_w), .somi_o(somi_o), .somi_oe_o(somi_oe_o)
  );

  sppf_peer peer (
    .mclk_i(mclk_i), .role_i(master), .pol_i(pol), .pha_i(pha), .len_i(len),
    .sclk_i(sclk_w), .ste_n_i(ste_w), .simo_i(simo_w), .somi_i(somi_w),
    .somi_o(p_somi), .sclk_o(p_sclk), .ste_n_o(p_ste_n), .simo_o(p_simo)
  );

  // clock, pattern for released lines, finished-word pulse count
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) flip <= !flip;
  always @(posedge mclk_i) if (rx_word_o === 1'b1) n_words <= n_words + 1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // bounded wait for a level, seen at falling edges
  task automatic wt(ref logic s, input logic v, input string m);
    int n;
    n = 0;
    while (s !== v && n < 6000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(s, v, m);
  endtask : wt

  task automatic cnt(ref logic s, input logic v, output int n);
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (s !== v && n < 400);
  endtask : cnt

  task automatic push(input logic [15:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge mclk_i);
    tx_valid = 1'b0;
  endtask : push

  // one pop, then room for the head word to settle
  task automatic pop();
    rx_ready = 1'b1;
    @(negedge mclk_i);
    rx_ready = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : pop

  task automatic fill(output int n);
    n = 0;
    while (tx_ready_o === 1'b1 && n < 20) begin
      push(16'(seq));
      seq++;
      n++;
      @(negedge mclk_i);
    end
  endtask : fill

  // master word in one clock scheme, both ways when transmit is enabled
  task automatic mx(input logic pl, ph, tk, input logic [3:0] ln, input logic [15:0] tw, pw);
    logic [15:0] m;
    m = 16'hFFFF >> (15 - ln);
    pol = pl;
    pha = ph;
    talk = tk;
    len = ln;
    peer.tx_word = pw;
    peer.rx_word = 16'h0000;
    repeat (2) @(negedge mclk_i);
    chk(sclk_w, pl, "idle level");
    push(tw);
    wt(ste_n_o, 1'b0, "select low");
    chk(simo_oe_o, tk, "data drive");
    wt(rx_valid_o, 1'b1, "rx valid");
    chk(rx_data_o, pw & m, "master rx");
    pop();
    wt(ste_n_o, 1'b1, "select high");
    if (tk) chk(peer.rx_word, tw & m, "master tx");
    $display("test master %0d%0d%0d done", pl, ph, tk);
  endtask : mx

  // select lead, half periods and select tail for one baud setting
  task automatic tm(input logic [6:0] b);
    int p;
    int a;
    int n;
    p = (b < 3) ? 4 : b + 1;
    {pol, pha, talk} = 3'h1;
    baud = b;
    len = 4'h1;
    @(negedge mclk_i);
    push(16'h0002);
    wt(ste_n_o, 1'b0, "select low");
    cnt(sclk_o, 1'b1, n);
    chk(n, p + p / 2 - 3, "lead");
    cnt(sclk_o, 1'b0, a);
    chk(a, (p + 1) / 2, "first half");
    cnt(sclk_o, 1'b1, n);
    chk(a + n, p, "period");
    cnt(sclk_o, 1'b0, n);
    cnt(ste_n_o, 1'b1, n);
    chk(n, p / 2, "tail");
    wt(rx_valid_o, 1'b1, "rx valid");
    pop();
    $display("test baud %0d done", b);
  endtask : tm

  // slave role: deselected clock, fifo depths, overrun and drain
  task automatic t_fifo();
    int n;
    int w0;
    logic [15:0] e;
    {master, fen, talk} = 3'h1;
    len = 4'h3;
    repeat (2) @(negedge mclk_i);
    w0 = n_words;
    peer.wiggle(12);
    chk(n_words - w0, 0, "deselected clock");
    chk(somi_oe_o, 1'b0, "deselected drive");
    fill(n);
    chk(n, 1, "bypass depth");
    fen = 1'b1;
    @(negedge mclk_i); // new limit reaches ready one cycle later
    fill(n);
    chk(n, 15, "fifo depth");
    for (int j = 0; j < 17; j++) begin
      pol = j[1];
      pha = j[0];
      peer.tx_word = 16'(j * 3);
      peer.rx_word = 16'h0000;
      peer.xfer(4);
      // select still low after a word lets the port load the next queued word,
      // which the release then drops: frame j carries queued word 2j+1 for j below 8, then zero
      e = (j < 8) ? 16'(2 * j + 1) & 16'h000F : 16'h0000;
      chk(peer.rx_word, e, "slave tx");
    end
    repeat (3) @(negedge mclk_i);
    chk(n_words - w0, 17, "word pulses");
    chk(ovr_o, 1'b1, "overrun");
    for (int j = 0; j < 16; j++) begin
      chk(rx_data_o, 16'(j * 3) & 16'h000F, "slave rx");
      pop();
    end
    chk(rx_valid_o, 1'b0, "rx empty");
    ovr_clr = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(ovr_o, 1'b0, "overrun clear");
    $display("test slave fifo done");
  endtask : t_fifo

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // watchdog: all tests need well under a tenth of this span
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog", $time);
    test_done();
  end

  initial begin
    {master, talk, fen} = 3'h7;
    {pol, pha, tx_valid, rx_ready, ovr_clr, flip} = 6'h00;
    len = 4'h0;
    baud = 7'h00;
    tx_data = 16'h0000;
    repeat (7) @(negedge mclk_i);
    chk(ste_n_o, 1'b1, "reset select");
    chk(sclk_oe_o, 1'b0, "reset clock drive");
    chk(tx_ready_o, 1'b1, "reset ready");
    @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(sclk_oe_o, 1'b1, "master clock drive");
    for (int i = 0; i < 4; i++) begin
      mx(i[1], i[0], 1'b1, 4'(i * 5), 16'hA5C3 ^ 16'(i), 16'h3C5A + 16'(i));
    end
    mx(1'b0, 1'b1, 1'b0, 4'h7, 16'h00A5, 16'h005A);
    foreach (seq_b[k]) tm(seq_b[k]);
    t_fifo();
    test_done();
  end
endmodule : sppf_core_tb_top
